// ### rtl/spc_fifo.sv
// Word FIFO for the serial port; single-entry limit for legacy mode.
// Qualifies push and pop itself with ready and valid; callers need not.
`timescale 1ns/1ns
`default_nettype none

module spc_fifo
   import spc_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int CW    = $clog2(DEPTH + 1)
)(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             flush,
   input  wire logic             single,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready,
   output logic [CW-1:0]         count
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   // Legacy mode counts as full after one word
   assign in_ready  = single ? (count == '0) : (count != CW'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= bump(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= bump(rd_ptr);
         end
         count <= CW'(count + CW'(push) - CW'(pop));
      end
   end

endmodule

`default_nettype wire

// ### rtl/spc_params.svh
// Constants of the serial port control block: offsets, fields, resets.
// Assumes a 10 MHz clock and a 32-bit classic Wishbone register bus.
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

`define SPC_OFF_STAT      4'h0
`define SPC_OFF_CON1      4'h4
`define SPC_OFF_CON2      4'h8
`define SPC_OFF_BUF       4'hC

`define SPC_STAT_EN_BIT   15
`define SPC_STAT_IDLE_BIT 13
`define SPC_STAT_OVF_BIT  6
`define SPC_STAT_MODE_LSB 2

`define SPC_CON1_MASK     16'h1FFF
`define SPC_CON2_MASK     16'hE003
`define SPC_CON1_RESET    16'h0000
`define SPC_CON2_RESET    16'h0000

`define SPC_MIN_RATIO     10'h002
`define SPC_COUNT_MAX     3'h7
`define SPC_BYTE_LAST     4'h7
`define SPC_WORD_LAST     4'hF

`endif

// ### rtl/spc_pkg.sv
// Types shared by the serial port control block.
// Assumes spc_params.svh supplies the numeric constants.
package spc_pkg;

   typedef struct packed {
      logic [2:0] unused;
      logic       clock_pin_disable;
      logic       data_out_pin_disable;
      logic       word_width_select;
      logic       input_sample_phase;
      logic       clock_edge_select;
      logic       select_pin_enable;
      logic       clock_polarity_select;
      logic       master_enable;
      logic [2:0] secondary_prescale;
      logic [1:0] primary_prescale;
   } spc_con1_t;

   typedef struct packed {
      logic        framed_mode_enable;
      logic        frame_sync_direction;
      logic        frame_sync_polarity;
      logic [10:0] unused;
      logic        frame_sync_edge;
      logic        fifo_buffer_enable;
   } spc_con2_t;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic sdo_o;
      logic sdo_oe;
      logic ss_o;
      logic ss_oe;
   } spc_pin_out_t;

   typedef enum logic [1:0] {
      spc_m_idle = 2'b00,
      spc_m_pre  = 2'b01,
      spc_m_bit  = 2'b10
   } spc_mstate_t;

endpackage

// ### rtl/spc_top.sv
// Serial port control block: Wishbone registers, master clock divider,
// master and slave shift engine, framed sync and pin drivers.
// Assumes pin inputs are already synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "spc_params.svh"

module spc_top
   import spc_pkg::*;
#(
   parameter int DEPTH = 8
)(
   input  wire logic   clk,
   input  wire logic   rst_b,
   input  wire logic   wb_cyc_i,
   input  wire logic   wb_stb_i,
   input  wire logic   wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic        wb_ack_o,
   input  wire logic   sck_i,
   input  wire logic   sdi_i,
   input  wire logic   ss_i,
   output spc_pin_out_t pin_out
);
   localparam int CW = $clog2(DEPTH + 1);

   // ==========================================================
   // Declarations
   spc_con1_t   con1;
   spc_con2_t   con2;
   logic        port_enable;
   logic        idle_stop;
   logic        rx_overflow_flag;
   logic [2:0]  int_mode;
   logic        bus_req;
   logic        wr_req;
   logic        rd_buf;
   logic [15:0] wr_merged;
   logic [15:0] stat_rd;
   logic [15:0] rd_value;
   logic        tx_ready;
   logic        tx_valid;
   logic [15:0] tx_head;
   logic [CW-1:0] tx_count;
   logic        rx_ready;
   logic        rx_valid;
   logic [15:0] rx_head;
   logic [CW-1:0] rx_count;
   logic [CW-1:0] elem_count;
   logic        tx_buffer_full_flag;
   logic        rx_buffer_full_flag;
   logic        framed;
   logic        cpol;
   logic        cke_eff;
   logic        wide;
   logic [9:0]  ratio;
   logic [9:0]  half0;
   logic [9:0]  half1;
   spc_mstate_t mst;
   logic        half;
   logic [9:0]  div_cnt;
   logic        m_mode;
   logic        m_tick;
   logic        m_go;
   logic        m_start;
   logic        m_mid;
   logic        m_end;
   logic        m_pulse;
   logic        m_sck;
   logic        frame_in_act;
   logic        s_mode;
   logic        sck_prev;
   logic        lead;
   logic        trail;
   logic        s_busy;
   logic        armed;
   logic        s_drive;
   logic        sel_ok;
   logic        frame_seen;
   logic        s_begin;
   logic        s_start;
   logic        s_abort;
   logic [15:0] shift_register;
   logic [15:0] rx_shift;
   logic [3:0]  bit_idx;
   logic        last_bit;
   logic        engine_busy;
   logic        ev_load;
   logic        ev_shift;
   logic        ev_sample;
   logic        word_done;
   logic        rx_drop;
   logic [15:0] rx_word;
   logic        out_bit;

   // ==========================================================
   // Helpers
   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
      return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction

   function automatic logic [9:0] spc_ratio(input logic [1:0] pp,
                                            input logic [2:0] sp);
      logic [9:0] pri;
      logic [9:0] sec;
      logic [9:0] prod;
      case (pp)
         2'b11:   pri = 10'h001;
         2'b10:   pri = 10'h004;
         2'b01:   pri = 10'h010;
         default: pri = 10'h040;
      endcase
      sec  = 10'(4'h8 - {1'b0, sp});
      prod = 10'(pri * sec);
      // Invalid 1:1 pair runs at the fastest legal rate instead
      if (prod < `SPC_MIN_RATIO) begin
         prod = `SPC_MIN_RATIO;
      end
      return prod;
   endfunction

   // ==========================================================
   // Mode decode
   assign framed   = con2.framed_mode_enable;
   assign cpol     = con1.clock_polarity_select;
   assign cke_eff  = con1.clock_edge_select & ~framed;
   assign wide     = con1.word_width_select;
   assign m_mode   = port_enable & con1.master_enable;
   assign s_mode   = port_enable & ~con1.master_enable;
   assign last_bit = (bit_idx == (wide ? `SPC_WORD_LAST : `SPC_BYTE_LAST));
   assign frame_in_act = (ss_i == con2.frame_sync_polarity);

   // ==========================================================
   // Wishbone slave: one wait state, ack for one cycle
   assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_req    = bus_req & wb_we_i;
   assign rd_buf    = bus_req & ~wb_we_i & (wb_adr_i == `SPC_OFF_BUF);
   assign wr_merged = lane_merge(16'h0000, wb_dat_i, wb_sel_i);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req & ~wb_we_i) begin
            wb_dat_o <= {16'h0000, rd_value};
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         con1 <= spc_con1_t'(`SPC_CON1_RESET);
         con2 <= spc_con2_t'(`SPC_CON2_RESET);
      end else if (wr_req) begin
         if (wb_adr_i == `SPC_OFF_CON1) begin
            con1 <= spc_con1_t'(lane_merge(con1, wb_dat_i, wb_sel_i)
                                & `SPC_CON1_MASK);
         end
         if (wb_adr_i == `SPC_OFF_CON2) begin
            con2 <= spc_con2_t'(lane_merge(con2, wb_dat_i, wb_sel_i)
                                & `SPC_CON2_MASK);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         port_enable <= 1'b0;
         idle_stop   <= 1'b0;
         int_mode    <= 3'h0;
      end else if (wr_req && (wb_adr_i == `SPC_OFF_STAT)) begin
         if (wb_sel_i[1]) begin
            port_enable <= wb_dat_i[`SPC_STAT_EN_BIT];
            idle_stop   <= wb_dat_i[`SPC_STAT_IDLE_BIT];
         end
         if (wb_sel_i[0]) begin
            int_mode <= wb_dat_i[`SPC_STAT_MODE_LSB +: 3];
         end
      end
   end

   // Overflow is clear-only from software; a new drop wins the cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_overflow_flag <= 1'b0;
      end else if (rx_drop) begin
         rx_overflow_flag <= 1'b1;
      end else if (wr_req && (wb_adr_i == `SPC_OFF_STAT) && wb_sel_i[0]
                   && !wb_dat_i[`SPC_STAT_OVF_BIT]) begin
         rx_overflow_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Status and read mux
   assign tx_buffer_full_flag = ~tx_ready;
   assign rx_buffer_full_flag = ~rx_ready;
   assign elem_count = con1.master_enable ? tx_count : rx_count;

   assign stat_rd = {port_enable, 1'b0, idle_stop, 2'b00,
                     (elem_count > CW'(`SPC_COUNT_MAX)) ? `SPC_COUNT_MAX
                                                        : elem_count[2:0],
                     ~engine_busy, rx_overflow_flag, ~rx_valid, int_mode,
                     tx_buffer_full_flag, rx_buffer_full_flag};

   always_comb begin
      case (wb_adr_i)
         `SPC_OFF_STAT: rd_value = stat_rd;
         `SPC_OFF_CON1: rd_value = con1;
         `SPC_OFF_CON2: rd_value = con2;
         `SPC_OFF_BUF:  rd_value = rx_valid ? rx_head : 16'h0000;
         default:       rd_value = 16'h0000;
      endcase
   end

   // ==========================================================
   // Holding buffers; single entry unless the FIFO mode is on
   spc_fifo #(
      .WIDTH (16),
      .DEPTH (DEPTH),
      .CW    (CW)
   ) tx_holding_buffer (
      .clk       (clk),
      .rst_b     (rst_b),
      .flush     (~port_enable),
      .single    (~con2.fifo_buffer_enable),
      .in_valid  (wr_req && (wb_adr_i == `SPC_OFF_BUF)),
      .in_data   (wr_merged),
      .in_ready  (tx_ready),
      .out_valid (tx_valid),
      .out_data  (tx_head),
      .out_ready (ev_load),
      .count     (tx_count)
   );

   spc_fifo #(
      .WIDTH (16),
      .DEPTH (DEPTH),
      .CW    (CW)
   ) rx_holding_buffer (
      .clk       (clk),
      .rst_b     (rst_b),
      .flush     (~port_enable),
      .single    (~con2.fifo_buffer_enable),
      .in_valid  (word_done),
      .in_data   (rx_word),
      .in_ready  (rx_ready),
      .out_valid (rx_valid),
      .out_data  (rx_head),
      .out_ready (rd_buf),
      .count     (rx_count)
   );

   assign rx_drop = word_done & ~rx_ready;

   // ==========================================================
   // Master clock generator
   assign ratio   = spc_ratio(con1.primary_prescale,
                              con1.secondary_prescale);
   assign half0   = ratio >> 1;
   assign half1   = 10'(ratio - half0);
   assign m_tick  = (div_cnt == 10'h001);
   assign m_go    = ~framed | ~con2.frame_sync_direction | frame_in_act;
   assign m_start = m_mode & (mst == spc_m_idle) & tx_valid & m_go;
   assign m_mid   = (mst == spc_m_bit) & ~half & m_tick;
   assign m_end   = (mst == spc_m_bit) & half & m_tick;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mst     <= spc_m_idle;
         half    <= 1'b0;
         div_cnt <= 10'h001;
      end else if (!m_mode) begin
         mst     <= spc_m_idle;
         half    <= 1'b0;
      end else begin
         case (mst)
            spc_m_idle: begin
               if (m_start) begin
                  mst     <= (framed & ~con2.frame_sync_edge) ? spc_m_pre
                                                             : spc_m_bit;
                  half    <= 1'b0;
                  div_cnt <= half0;
               end
            end
            spc_m_pre, spc_m_bit: begin
               if (m_tick) begin
                  half    <= ~half;
                  div_cnt <= half ? half0 : half1;
                  if (half && (mst == spc_m_pre)) begin
                     mst <= spc_m_bit;
                  end else if (half && last_bit) begin
                     mst <= spc_m_idle;
                  end
               end else begin
                  div_cnt <= 10'(div_cnt - 10'h001);
               end
            end
            default: mst <= spc_m_idle;
         endcase
      end
   end

   // Clock active in first half when data changes on the leading edge
   assign m_sck   = (mst == spc_m_idle) ? cpol
                                        : cpol ^ (cke_eff ? half : ~half);
   assign m_pulse = framed & ~con2.frame_sync_direction &
                    ((mst == spc_m_pre) |
                     (con2.frame_sync_edge & (mst == spc_m_bit) &
                      (bit_idx == 4'h0)));

   // ==========================================================
   // Slave edge detection and framing
   assign lead    = (sck_prev == cpol) & (sck_i != cpol);
   assign trail   = (sck_prev != cpol) & (sck_i == cpol);
   assign sel_ok  = ~con1.select_pin_enable | ~ss_i;
   assign frame_seen = con2.frame_sync_direction ? frame_in_act : s_drive;
   assign s_begin = framed ? (con2.frame_sync_edge ? frame_seen : armed)
                           : sel_ok;
   assign s_start = s_mode & ~s_busy & lead & s_begin;
   assign s_abort = s_mode & ~framed & con1.select_pin_enable & ss_i;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sck_prev <= 1'b0;
         s_busy   <= 1'b0;
      end else begin
         sck_prev <= sck_i;
         if (!s_mode || s_abort) begin
            s_busy <= 1'b0;
         end else if (s_start) begin
            s_busy <= 1'b1;
         end else if (word_done) begin
            s_busy <= 1'b0;
         end
      end
   end

   // Frame pulse seen one clock ahead of the word when edge bit is clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         armed   <= 1'b0;
         s_drive <= 1'b0;
      end else begin
         if (!s_mode || !framed || s_start) begin
            armed <= 1'b0;
         end else if (~s_busy & lead & ~con2.frame_sync_edge & frame_seen) begin
            armed <= 1'b1;
         end
         s_drive <= s_mode & framed & ~con2.frame_sync_direction &
                    ~s_busy & ~armed & ~(lead & s_drive);
      end
   end

   // ==========================================================
   // Shared shift engine
   assign engine_busy = m_mode ? (mst != spc_m_idle) : s_busy;
   assign ev_load     = m_start | s_start;
   assign ev_shift    = m_mode ? (m_end & ~last_bit)
                               : (s_busy & (cke_eff ? trail : lead));
   assign ev_sample   = m_mode ?
                        (con1.input_sample_phase ? m_end : m_mid) :
                        (cke_eff ? ((s_busy | s_start) & lead)
                                 : (s_busy & trail));
   assign word_done   = ev_sample & last_bit;
   assign rx_word     = wide ? {rx_shift[14:0], sdi_i}
                             : {8'h00, rx_shift[6:0], sdi_i};
   assign out_bit     = wide ? shift_register[15] : shift_register[7];

   // Idle engine keeps the next word on the pin for a leading-edge slave
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_register <= 16'h0000;
         bit_idx        <= 4'h0;
      end else if (ev_load) begin
         shift_register <= tx_valid ? tx_head : 16'h0000;
         bit_idx        <= 4'h0;
      end else if (ev_shift) begin
         shift_register <= {shift_register[14:0], 1'b0};
         bit_idx        <= 4'(bit_idx + 4'h1);
      end else if (!engine_busy) begin
         shift_register <= tx_valid ? tx_head : 16'h0000;
         bit_idx        <= 4'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_shift <= 16'h0000;
      end else if (ev_sample) begin
         rx_shift <= {rx_shift[14:0], sdi_i};
      end
   end

   // ==========================================================
   // Pin drivers; a disabled port releases every pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out <= '0;
      end else begin
         pin_out.sck_oe <= m_mode & ~con1.clock_pin_disable;
         pin_out.sck_o  <= m_sck;
         pin_out.sdo_oe <= port_enable & ~con1.data_out_pin_disable &
                           (m_mode | framed | sel_ok);
         pin_out.sdo_o  <= out_bit;
         pin_out.ss_oe  <= port_enable & framed &
                           ~con2.frame_sync_direction;
         pin_out.ss_o   <= con2.frame_sync_polarity ^
                           ~(m_mode ? m_pulse : s_drive);
      end
   end

endmodule

`default_nettype wire

// ### sim/spc_peer.sv
// Peripheral on the far side of the link, one word per load pulse.
// Assumes the block is master and drives clock and data out.
`timescale 1ns/1ns
`default_nettype none
module spc_peer (
   input  wire logic        sck,
   input  wire logic        sdo,
   input  wire logic        pol,
   input  wire logic        edg,
   input  wire logic        load,
   input  wire logic [15:0] word,
   output logic             sdi,
   output logic [15:0]      got
);
   logic [15:0] sh = 16'h0000;
   logic        first = 1'h0;
   assign sdi = sh[15];
   always @(posedge load) begin
      sh = word;
      first = 1'h1;
      got = 16'h0000;
   end
   // Spent bits refill with toggles so a late sample never looks right
   always @(sck) begin
      if ((sck != pol) ^ edg) begin
         if (first && !edg) first = 1'h0;
         else sh = {sh[14:0], ~sh[15]};
      end else begin
         got = {got[14:0], sdo};
      end
   end
endmodule
`default_nettype wire

// ### sim/spc_props.sv
// Checker bound to the serial port top; sees bus and pin ports only.
// Assumes control registers change only while the port is disabled.
`timescale 1ns/1ns
`default_nettype none
module spc_props
   import spc_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst_b,
   input wire logic         wb_cyc_i,
   input wire logic         wb_stb_i,
   input wire logic         wb_we_i,
   input wire logic [3:0]   wb_adr_i,
   input wire logic [3:0]   wb_sel_i,
   input wire logic [31:0]  wb_dat_i,
   input wire logic [31:0]  wb_dat_o,
   input wire logic         wb_ack_o,
   input wire spc_pin_out_t pin_out
);
   // ====
   // Shadows of control bits, taken from bus writes
   logic [15:0] con1;
   logic [15:0] con2;
   logic        en;
   wire logic   wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   wire logic   rd = wb_ack_o & ~wb_we_i;
   wire logic   both = &wb_sel_i[1:0];
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         con1 <= 16'h0000;
         con2 <= 16'h0000;
         en   <= 1'h0;
      end else if (wr) begin
         if (wb_adr_i == 4'h4 && wb_sel_i[0]) con1[7:0] <= wb_dat_i[7:0];
         if (wb_adr_i == 4'h4 && wb_sel_i[1]) con1[15:8] <= wb_dat_i[15:8];
         if (wb_adr_i == 4'h8 && both) con2 <= wb_dat_i[15:0];
         if (wb_adr_i == 4'h0 && both) en <= wb_dat_i[15];
      end
   end
   // ====
   // Properties; pins lag the registers by one cycle
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_port_off: assert property (
      !en |=> !pin_out.sck_oe && !pin_out.sdo_oe && !pin_out.ss_oe)
      else $error("pin driven while port is off");
   chk_slave_clock: assert property (
      !con1[5] |=> !pin_out.sck_oe) else $error("slave drives clock");
   chk_sck_release: assert property (
      con1[12] |=> !pin_out.sck_oe) else $error("clock pin not released");
   chk_sdo_release: assert property (
      con1[11] |=> !pin_out.sdo_oe) else $error("data pin not released");
   chk_frame_release: assert property (
      !(en && con2[15] && !con2[14]) |=> !pin_out.ss_oe)
      else $error("frame pin driven while not frame master");
   chk_clock_idle: assert property (
      $rose(pin_out.sck_oe) |-> pin_out.sck_o == con1[6])
      else $error("clock not at idle level");
   chk_data_edge: assert property (
      en && con1[5] && !con2[15] && $past(pin_out.sck_oe)
      && $changed(pin_out.sck_o) && pin_out.sck_o == (con1[6] ^ con1[8])
      |-> $stable(pin_out.sdo_o)) else $error("data changed on wrong edge");
   chk_con1_read: assert property (
      rd && wb_adr_i == 4'h4 |-> wb_dat_o == {19'h00000, con1[12:0]})
      else $error("control one read wrong");
   chk_con2_read: assert property (
      rd && wb_adr_i == 4'h8 |-> wb_dat_o == {16'h0000, con2 & 16'hE003})
      else $error("control two read wrong");
   cover property ($rose(pin_out.sck_o));
   cover property (con1[8] && $fell(pin_out.sck_o));
   cover property (rd && wb_adr_i == 4'hC);
endmodule
bind spc_top spc_props u_props (.clk, .rst_b, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .pin_out);
`default_nettype wire

// ### sim/spc_tb_top.sv
// Bench: bus tasks program the block, a peripheral model answers.
// Assumes a 100 ns clock and one bus answer per request.
`timescale 1ns/1ns
`default_nettype none
module spc_tb_top
   import spc_pkg::*;
;
   logic         clk   = 1'h0;
   logic         rst_b = 1'h0;
   logic         cyc   = 1'h0;
   logic         stb   = 1'h0;
   logic         we    = 1'h0;
   logic         load  = 1'h0;
   logic [3:0]   adr   = 4'h0;
   logic [3:0]   sel   = 4'hF;
   logic [15:0]  dat   = 16'h0000;
   logic [15:0]  cfg   = 16'h0000;
   logic [15:0]  word  = 16'h0000;
   logic [15:0]  got;
   logic [31:0]  rdat;
   logic [31:0]  s;
   logic         ack;
   logic         sdi;
   spc_pin_out_t pin_out;
   int           miscompares = 0;
   int           comparisons = 0;
   int           n;
   int           div[4] = '{2, 3, 8, 64};
   logic [5:0]   pre[4] = '{6'h3B, 6'h37, 6'h23, 6'h3C};
   spc_top DUT (.clk, .rst_b, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i({16'h0000, dat}),
      .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(1'h0), .sdi_i(sdi),
      .ss_i(1'h1), .pin_out);
   spc_peer PEER (.sck(pin_out.sck_o), .sdo(pin_out.sdo_o), .pol(cfg[6]),
      .edg(cfg[8]), .load, .word, .sdi, .got);
   always #50 clk = ~clk;
   // ====
   // Tasks
   task automatic bus(input logic w, input logic [3:0] a,
         input logic [15:0] d);
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we  <= w;
      adr <= a;
      dat <= d;
      // Request held until the rising edge that sees ack high
      do @(posedge clk); while (ack !== 1'h1);
      s = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic per(output int c);
      logic p;
      @(negedge clk);
      do begin
         p = pin_out.sck_o;
         @(negedge clk);
      end while (!(pin_out.sck_o && !p));
      c = 0;
      do begin
         p = pin_out.sck_o;
         @(negedge clk);
         c++;
      end while (!(pin_out.sck_o && !p));
   endtask
   task automatic print_verdict;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ====
   // Tests
   initial begin
      #3000000;
      miscompares++;
      print_verdict;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      bus(1'h0, 4'h0, 16'h0000);
      chk(s, 32'h00A0);
      bus(1'h0, 4'h4, 16'h0000);
      chk(s, 32'h0);
      bus(1'h1, 4'h4, 16'hFFFF);
      sel <= 4'h1;
      bus(1'h1, 4'h4, 16'h0000);
      sel <= 4'hF;
      bus(1'h0, 4'h4, 16'h0000);
      chk(s, 32'h1F00);
      bus(1'h1, 4'h8, 16'hFFFF);
      bus(1'h0, 4'h8, 16'h0000);
      chk(s, 32'hE003);
      bus(1'h0, 4'h2, 16'h0000);
      chk(s, 32'h0);
      foreach (pre[i]) begin
         bus(1'h1, 4'h0, 16'h0000);
         bus(1'h1, 4'h4, {10'h000, pre[i]});
         bus(1'h1, 4'h8, 16'h0000);
         bus(1'h1, 4'h0, 16'h8000);
         bus(1'h1, 4'hC, 16'h005A);
         per(n);
         chk(32'(n), 32'(div[i]));
      end
      for (int m = 0; m < 4; m++) begin
         // Master and unframed only
         cfg = {5'h00, m[0] ^ m[1], ~m[0], m[1], 1'h0, m[0], 6'h3D};
         word = 16'hC3A5 + 16'(m);
         bus(1'h1, 4'h0, 16'h0000);
         bus(1'h1, 4'h4, cfg);
         bus(1'h1, 4'h8, {15'h0000, m == 3});
         bus(1'h1, 4'h0, 16'h8000);
         load <= 1'h1;
         @(posedge clk);
         load <= 1'h0;
         bus(1'h1, 4'hC, 16'h9E17);
         bus(1'h0, 4'h0, 16'h0000);
         chk(s[1], 1'h0);
         bus(1'h1, 4'hC, 16'h4BD2);
         bus(1'h0, 4'h0, 16'h0000);
         chk(s[1], m != 3);
         do bus(1'h0, 4'h0, 16'h0000);
         while (s[10:8] != 3'h0 || s[1] || !s[7]);
         chk({s[6], s[5], s[0]}, {m != 3, 1'h0, m != 3});
         bus(1'h0, 4'hC, 16'h0000);
         chk(s, (m[0] ^ m[1]) ? {16'h0, word} : {24'h0, word[15:8]});
         bus(1'h0, 4'h0, 16'h0000);
         chk(s[0], 1'h0);
         chk(got, (m[0] ^ m[1]) ? 16'h4BD2 : 16'h17D2);
      end
      print_verdict;
   end
endmodule
`default_nettype wire
